// file: rtl/esc_checker.v
// Enclave signature record checker for the enclave launch leaf.
// Assumes a byte-wide memory read port and an external RSA/hash engine,
// all on clk; capability and enclave inputs steady while busy.
// Functional notes
// - first 16 bytes equal fixed header stream
// - bytes 24..39 equal second header stream
// - digest is eight little-endian words
// - big integers stored least significant byte first
// - exponent word at 512 must be 3
// - 3072-bit modulus sits at offset 128
// - first quotient at 1040 feeds verification
// - second quotient at 1424 feeds verification
// - record must start on page boundary
// - only bytes 0-127 and 900-1027 hashed
// - select zero when enumerated feature field zero
// - control-flow bytes zero without capability bit
// - masked required attributes must match enclave
// - measurement field matches enclave measurement
// - software free word is never interpreted
`timescale 1ns/1ps
`include "esc_map.vh"

module esc_checker #(
  parameter AW = 64,
  parameter [127:0] HDR1 = `ESC_HDR1_VAL,
  parameter [127:0] HDR2 = `ESC_HDR2_VAL
) (
  input wire clk,
  input wire resetn,
  input wire start,
  input wire [AW-1:0] rec_addr,
  input wire [31:0] cap_ebx,
  input wire cap_eax6,
  input wire [255:0] enclave_measurement,
  input wire [127:0] enclave_attributes,
  output wire mem_rd_req,
  output wire [AW-1:0] mem_rd_addr,
  input wire mem_rd_valid,
  input wire [7:0] mem_rd_data,
  output wire hash_valid,
  output wire [7:0] hash_byte,
  output wire int_valid,
  output wire [1:0] int_sel,
  output wire [8:0] int_idx,
  output wire [7:0] int_byte,
  output wire sig_check_start,
  input wire sig_check_done,
  input wire sig_check_ok,
  output wire busy,
  output wire done,
  output wire launch_ok,
  output wire [`ESC_F_W-1:0] fail_flags
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_FETCH = 2'h1;
  localparam [1:0] ST_SIGW = 2'h2;

  reg [1:0] state_q;
  reg [AW-1:0] addr_q;
  reg [10:0] ofs_q;
  reg req_q;
  reg busy_q;
  reg done_q;
  reg ok_q;
  reg sig_start_q;
  reg ebx_zero_q;
  reg eax6_q;
  reg [`ESC_F_W-1:0] fail_q;
  reg [31:0] sel_q;
  reg [127:0] req_attr_q;
  reg hash_valid_q;
  reg [7:0] hash_byte_q;
  reg int_valid_q;
  reg [1:0] int_sel_q;
  reg [8:0] int_idx_q;
  reg [7:0] int_byte_q;

  wire hdr_bad;
  wire rsvd_bad;
  wire exp_bad;
  wire cfa_bad;
  wire sel_zero_bad;
  wire meas_bad;
  wire hash_en;
  wire int_en;
  wire [1:0] cur_sel;
  wire [8:0] cur_idx;

  ////////////////////////////////////////////////////////////////////////
  // Two-digit hex-coded decimal within [lo, hi]
  function bcd_ok;
    input [7:0] b;
    input [7:0] lo;
    input [7:0] hi;
    begin
      bcd_ok = (b[3:0] <= 4'h9) && (b >= lo) && (b <= hi);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Field classifier for the byte now on the read port
  esc_byte_check #(
    .HDR1(HDR1),
    .HDR2(HDR2)
  ) u_byte (
    .ofs(ofs_q),
    .data(mem_rd_data),
    .ebx_zero(ebx_zero_q),
    .cap_eax6(eax6_q),
    .enclave_measurement(enclave_measurement),
    .hdr_bad(hdr_bad),
    .rsvd_bad(rsvd_bad),
    .exp_bad(exp_bad),
    .cfa_bad(cfa_bad),
    .sel_zero_bad(sel_zero_bad),
    .meas_bad(meas_bad),
    .hash_en(hash_en),
    .int_en(int_en),
    .int_sel(cur_sel),
    .int_idx(cur_idx)
  );

  ////////////////////////////////////////////////////////////////////////
  // Date check, and checks that need earlier bytes of the record
  reg date_bad;
  reg mask_bad;
  reg attr_bad;
  reg [7:0] sel_b;
  reg [7:0] rattr_b;
  reg [7:0] eattr_b;

  always @*
  begin
    sel_b = sel_q[{ofs_q[1:0], 3'h0} +: 8];
    rattr_b = req_attr_q[{ofs_q[3:0], 3'h0} +: 8];
    eattr_b = enclave_attributes[{ofs_q[3:0], 3'h0} +: 8];
    // Date word little-endian: day, month, then year bytes
    date_bad = 1'b0;
    if (ofs_q == `ESC_OFS_DATE)
      date_bad = !bcd_ok(mem_rd_data, 8'h01, 8'h31);
    else if (ofs_q == `ESC_OFS_DATE + 11'h001)
      date_bad = !bcd_ok(mem_rd_data, 8'h01, 8'h12);
    // Mask byte arrives after its select byte
    mask_bad = (ofs_q >= `ESC_OFS_MSK) && (ofs_q < `ESC_END_MSK)
      && ((sel_b & ~mem_rd_data) != 8'h00);
    attr_bad = (ofs_q >= `ESC_OFS_AMSK) && (ofs_q < `ESC_END_AMSK)
      && (((rattr_b ^ eattr_b) & mem_rd_data) != 8'h00);
  end

  // All failure causes of the present byte
  wire [`ESC_F_W-1:0] byte_fail;
  assign byte_fail[`ESC_F_HDR] = hdr_bad;
  assign byte_fail[`ESC_F_ALIGN] = 1'b0;
  assign byte_fail[`ESC_F_RSVD] = rsvd_bad;
  assign byte_fail[`ESC_F_EXP] = exp_bad;
  assign byte_fail[`ESC_F_DATE] = date_bad;
  assign byte_fail[`ESC_F_SEL] = sel_zero_bad | mask_bad;
  assign byte_fail[`ESC_F_CFA] = cfa_bad;
  assign byte_fail[`ESC_F_ATTR] = attr_bad;
  assign byte_fail[`ESC_F_MEAS] = meas_bad;
  assign byte_fail[`ESC_F_SIG] = 1'b0;

  wire last_byte = (ofs_q == `ESC_REC_LAST);
  wire misaligned = |rec_addr[`ESC_PAGE_BITS-1:0];

  ////////////////////////////////////////////////////////////////////////
  // Launch sequence: align check, byte fetch, signature verdict
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= ST_IDLE;
      addr_q <= {AW{1'b0}};
      ofs_q <= 11'h000;
      req_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      ok_q <= 1'b0;
      sig_start_q <= 1'b0;
      ebx_zero_q <= 1'b0;
      eax6_q <= 1'b0;
      fail_q <= {`ESC_F_W{1'b0}};
      sel_q <= 32'h0000_0000;
      req_attr_q <= 128'h0;
      hash_valid_q <= 1'b0;
      hash_byte_q <= 8'h00;
      int_valid_q <= 1'b0;
      int_sel_q <= 2'h0;
      int_idx_q <= 9'h000;
      int_byte_q <= 8'h00;
    end
    else
    begin
      done_q <= 1'b0;
      sig_start_q <= 1'b0;
      hash_valid_q <= 1'b0;
      int_valid_q <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (start)
          begin
            fail_q <= {`ESC_F_W{1'b0}};
            ok_q <= 1'b0;
            addr_q <= rec_addr;
            ofs_q <= 11'h000;
            ebx_zero_q <= (cap_ebx == 32'h0000_0000);
            eax6_q <= cap_eax6;
            // No fetch at all for a record off a page boundary
            if (misaligned)
            begin
              fail_q[`ESC_F_ALIGN] <= 1'b1;
              done_q <= 1'b1;
            end
            else
            begin
              req_q <= 1'b1;
              busy_q <= 1'b1;
              state_q <= ST_FETCH;
            end
          end
        end
        ST_FETCH:
        begin
          if (mem_rd_valid)
          begin
            fail_q <= fail_q | byte_fail;
            if (ofs_q >= `ESC_OFS_SEL && ofs_q < `ESC_OFS_MSK)
              sel_q[{ofs_q[1:0], 3'h0} +: 8] <= mem_rd_data;
            if (ofs_q >= `ESC_OFS_ATTR && ofs_q < `ESC_OFS_AMSK)
              req_attr_q[{ofs_q[3:0], 3'h0} +: 8] <= mem_rd_data;
            // Signed bytes go to the digest engine
            hash_valid_q <= hash_en;
            hash_byte_q <= mem_rd_data;
            // Integer bytes go to the RSA engine, LSB first
            int_valid_q <= int_en;
            int_sel_q <= cur_sel;
            int_idx_q <= cur_idx;
            int_byte_q <= mem_rd_data;
            if (last_byte)
            begin
              req_q <= 1'b0;
              sig_start_q <= 1'b1;
              state_q <= ST_SIGW;
            end
            else
            begin
              ofs_q <= ofs_q + 11'h001;
              addr_q <= addr_q + {{(AW-1){1'b0}}, 1'b1};
            end
          end
        end
        ST_SIGW:
        begin
          // Any recorded failure forces rejection
          if (sig_check_done)
          begin
            fail_q[`ESC_F_SIG] <= !sig_check_ok;
            ok_q <= sig_check_ok && (fail_q == {`ESC_F_W{1'b0}});
            done_q <= 1'b1;
            busy_q <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops
  assign mem_rd_req = req_q;
  assign mem_rd_addr = addr_q;
  assign hash_valid = hash_valid_q;
  assign hash_byte = hash_byte_q;
  assign int_valid = int_valid_q;
  assign int_sel = int_sel_q;
  assign int_idx = int_idx_q;
  assign int_byte = int_byte_q;
  assign sig_check_start = sig_start_q;
  assign busy = busy_q;
  assign done = done_q;
  assign launch_ok = ok_q;
  assign fail_flags = fail_q;

endmodule // esc_checker

// file: rtl/esc_map.vh
// Offsets, field sizes and constants of the enclave signature record.
// Assumes byte offsets relative to the record start, 11 bits wide.
`ifndef ESC_MAP_VH
`define ESC_MAP_VH

// Record size and paging
`define ESC_REC_LAST 11'h70f
`define ESC_PAGE_BITS 12
// Header fields
`define ESC_OFS_HDR1 11'h000
`define ESC_OFS_DATE 11'h014
`define ESC_OFS_HDR2 11'h018
`define ESC_OFS_SWW 11'h028
`define ESC_HDR_LEN 11'h010
// Constant byte streams, first byte in the top byte lane
`define ESC_HDR1_VAL 128'h06000000e1000000000010000000000
`define ESC_HDR2_VAL 128'h0101000060000000600000001000000
// Reserved regions that must read zero
`define ESC_OFS_RSV1 11'h02c
`define ESC_END_RSV1 11'h080
`define ESC_OFS_RSV2 11'h38e
`define ESC_END_RSV2 11'h390
`define ESC_OFS_RSV3 11'h3e0
`define ESC_END_RSV3 11'h3f0
`define ESC_OFS_RSV4 11'h404
`define ESC_END_RSV4 11'h410
// Big integers, exponent
`define ESC_OFS_MOD 11'h080
`define ESC_OFS_EXP 11'h200
`define ESC_END_EXP 11'h204
`define ESC_OFS_SIG 11'h204
`define ESC_OFS_QUO1 11'h410
`define ESC_OFS_QUO2 11'h590
`define ESC_INT_LEN 11'h180
`define ESC_EXP_VAL 8'h03
// Signed body fields
`define ESC_OFS_SEL 11'h384
`define ESC_OFS_MSK 11'h388
`define ESC_END_MSK 11'h38c
`define ESC_OFS_CFA 11'h38c
`define ESC_END_CFA 11'h38e
`define ESC_OFS_ATTR 11'h3a0
`define ESC_OFS_AMSK 11'h3b0
`define ESC_END_AMSK 11'h3c0
`define ESC_OFS_MEAS 11'h3c0
`define ESC_END_MEAS 11'h3e0
`define ESC_END_SIGNED 11'h404
// Integer selector codes
`define ESC_INT_MOD 2'h0
`define ESC_INT_SIG 2'h1
`define ESC_INT_QUO1 2'h2
`define ESC_INT_QUO2 2'h3
// Failure flag positions
`define ESC_F_HDR 0
`define ESC_F_ALIGN 1
`define ESC_F_RSVD 2
`define ESC_F_EXP 3
`define ESC_F_DATE 4
`define ESC_F_SEL 5
`define ESC_F_CFA 6
`define ESC_F_ATTR 7
`define ESC_F_MEAS 8
`define ESC_F_SIG 9
`define ESC_F_W 10

`endif

// file: rtl/esc_byte_check.v
// Per-byte classifier of the signature record: field checks and routing.
// Assumes one record byte and its offset, all inputs on the same clock.
`timescale 1ns/1ps
`include "esc_map.vh"

module esc_byte_check #(
  parameter [127:0] HDR1 = `ESC_HDR1_VAL,
  parameter [127:0] HDR2 = `ESC_HDR2_VAL
) (
  input wire [10:0] ofs,
  input wire [7:0] data,
  input wire ebx_zero,
  input wire cap_eax6,
  input wire [255:0] enclave_measurement,
  output reg hdr_bad,
  output reg rsvd_bad,
  output reg exp_bad,
  output reg cfa_bad,
  output reg sel_zero_bad,
  output reg meas_bad,
  output reg hash_en,
  output reg int_en,
  output reg [1:0] int_sel,
  output reg [8:0] int_idx
);

  // Offset lies in [lo, hi)
  function inr;
    input [10:0] o;
    input [10:0] lo;
    input [10:0] hi;
    begin
      inr = (o >= lo) && (o < hi);
    end
  endfunction

  wire [10:0] r2 = ofs - `ESC_OFS_HDR2;
  wire [10:0] rm = ofs - `ESC_OFS_MEAS;
  wire [10:0] rmod = ofs - `ESC_OFS_MOD;
  wire [10:0] rsig = ofs - `ESC_OFS_SIG;
  wire [10:0] rq1 = ofs - `ESC_OFS_QUO1;
  wire [10:0] rq2 = ofs - `ESC_OFS_QUO2;
  wire [3:0] h1i = 4'hf - ofs[3:0];
  wire [3:0] h2i = 4'hf - r2[3:0];

  ////////////////////////////////////////////////////////////////////////
  // Field decode; software free word and identifiers pass unchecked
  always @*
  begin
    hdr_bad = (inr(ofs, `ESC_OFS_HDR1, `ESC_HDR_LEN)
      && data != HDR1[{h1i, 3'h0} +: 8])
      || (inr(ofs, `ESC_OFS_HDR2, `ESC_OFS_SWW)
      && data != HDR2[{h2i, 3'h0} +: 8]);
    rsvd_bad = (data != 8'h00)
      && (inr(ofs, `ESC_OFS_RSV1, `ESC_END_RSV1)
      || inr(ofs, `ESC_OFS_RSV2, `ESC_END_RSV2)
      || inr(ofs, `ESC_OFS_RSV3, `ESC_END_RSV3)
      || inr(ofs, `ESC_OFS_RSV4, `ESC_END_RSV4));
    // Little-endian exponent word must read 3
    exp_bad = inr(ofs, `ESC_OFS_EXP, `ESC_END_EXP)
      && data != ((ofs == `ESC_OFS_EXP) ? `ESC_EXP_VAL : 8'h00);
    cfa_bad = !cap_eax6 && data != 8'h00
      && inr(ofs, `ESC_OFS_CFA, `ESC_END_CFA);
    sel_zero_bad = ebx_zero && data != 8'h00
      && inr(ofs, `ESC_OFS_SEL, `ESC_OFS_MSK);
    // Digest words little-endian: byte k sits at bits 8k of the vector
    meas_bad = inr(ofs, `ESC_OFS_MEAS, `ESC_END_MEAS)
      && data != enclave_measurement[{rm[4:0], 3'h0} +: 8];
    hash_en = (ofs < `ESC_OFS_MOD)
      || inr(ofs, `ESC_OFS_SEL, `ESC_END_SIGNED);
    // Integers stream least significant byte first
    int_en = 1'b1;
    int_sel = `ESC_INT_MOD;
    int_idx = rmod[8:0];
    if (inr(ofs, `ESC_OFS_SIG, `ESC_OFS_SEL))
    begin
      int_sel = `ESC_INT_SIG;
      int_idx = rsig[8:0];
    end
    else if (inr(ofs, `ESC_OFS_QUO1, `ESC_OFS_QUO2))
    begin
      int_sel = `ESC_INT_QUO1;
      int_idx = rq1[8:0];
    end
    else if (ofs >= `ESC_OFS_QUO2)
    begin
      int_sel = `ESC_INT_QUO2;
      int_idx = rq2[8:0];
    end
    else if (!inr(ofs, `ESC_OFS_MOD, `ESC_OFS_EXP))
      int_en = 1'b0;
  end

endmodule // esc_byte_check

// file: bench/esc_mem_model.sv
// Memory model holding one enclave signature record, byte per read.
// Assumes one outstanding read; answers after lat idle cycles.
`timescale 1ns/1ps
module esc_mem_model (
  input wire clk,
  input wire resetn,
  input wire mem_rd_req,
  input wire [63:0] mem_rd_addr,
  input wire [3:0] lat,
  output reg mem_rd_valid,
  output reg [7:0] mem_rd_data
);
  reg [7:0] rec [0:2047];
  reg [3:0] wait_q;

  // Record sits on a page, so the low address bits index it
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mem_rd_valid <= 1'b0;
      mem_rd_data <= 8'h00;
      wait_q <= 4'h0;
    end
    else if (mem_rd_req && !mem_rd_valid && wait_q == lat)
    begin
      mem_rd_valid <= 1'b1;
      mem_rd_data <= rec[mem_rd_addr[10:0]];
      wait_q <= 4'h0;
    end
    else
    begin
      mem_rd_valid <= 1'b0;
      mem_rd_data <= ~mem_rd_data; // Idle data toggles: stale byte inverted, then back every other cycle
      wait_q <= wait_q + {3'h0, mem_rd_req & ~mem_rd_valid};
    end
  end
endmodule // esc_mem_model

// file: bench/esc_chk.sv
// Checker for esc_checker: fetch order, stream routing, verdict timing.
// Assumes it is bound to every esc_checker instance.
`timescale 1ns/1ps
module esc_chk #(
  parameter AW = 64
) (
  input logic clk,
  input logic resetn,
  input logic start,
  input logic [AW-1:0] rec_addr,
  input logic mem_rd_req,
  input logic [AW-1:0] mem_rd_addr,
  input logic mem_rd_valid,
  input logic [7:0] mem_rd_data,
  input logic hash_valid,
  input logic [7:0] hash_byte,
  input logic int_valid,
  input logic [1:0] int_sel,
  input logic [8:0] int_idx,
  input logic [7:0] int_byte,
  input logic sig_check_start,
  input logic sig_check_done,
  input logic sig_check_ok,
  input logic busy,
  input logic done,
  input logic launch_ok,
  input logic [9:0] fail_flags
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Byte taken this cycle and its record offset
  wire tk = mem_rd_req & mem_rd_valid;
  wire [10:0] ofs = mem_rd_addr[10:0];
  wire go = start & ~busy;

  misalign_a: assert property (
    go && rec_addr[11:0] != 0 |=> done && fail_flags == 10'h002
    && !mem_rd_req) else $error("misaligned record not refused");
  first_read_a: assert property (
    go && rec_addr[11:0] == 0 |=> mem_rd_req
    && mem_rd_addr == $past(rec_addr)) else $error("bad first read");
  next_read_a: assert property (
    tk && ofs != 11'h70f |=> mem_rd_req
    && mem_rd_addr == $past(mem_rd_addr) + 1) else $error("bad next read");
  hold_read_a: assert property (
    mem_rd_req && !mem_rd_valid |=> mem_rd_req && $stable(mem_rd_addr))
    else $error("read dropped early");
  last_read_a: assert property (
    tk && ofs == 11'h70f |=> !mem_rd_req && sig_check_start)
    else $error("bad end of fetch");
  hash_head_a: assert property (
    tk && ofs < 11'd128 |=> hash_valid && hash_byte == $past(mem_rd_data))
    else $error("header byte not hashed");
  mod_route_a: assert property (
    tk && ofs >= 11'd128 && ofs < 11'd512 |=> int_valid && int_sel == 2'h0
    && {2'h0, int_idx} == $past(ofs) - 11'd128
    && int_byte == $past(mem_rd_data)) else $error("bad modulus byte");
  quo2_route_a: assert property (
    tk && ofs >= 11'd1424 |=> int_valid && int_sel == 2'h3
    && {2'h0, int_idx} == $past(ofs) - 11'd1424)
    else $error("bad second quotient byte");
  verdict_a: assert property (
    busy && sig_check_done |=> done && fail_flags[9] == !$past(sig_check_ok)
    && launch_ok == (fail_flags == 0)) else $error("bad verdict");
  done_once_a: assert property (
    done |=> !done) else $error("done longer than a cycle");
endmodule // esc_chk

bind esc_checker esc_chk #(.AW(AW)) u_chk (.clk, .resetn, .start,
  .rec_addr, .mem_rd_req, .mem_rd_addr, .mem_rd_valid, .mem_rd_data,
  .hash_valid, .hash_byte, .int_valid, .int_sel, .int_idx, .int_byte,
  .sig_check_start, .sig_check_done, .sig_check_ok, .busy, .done,
  .launch_ok, .fail_flags);

// file: bench/tb.sv
// Self-checking bench for esc_checker: record faults, routing, refusals.
// Assumes esc_mem_model holds the record; signature engine is prompt.
`timescale 1ns/1ps
`include "esc_map.vh"
module tb;
  reg clk, resetn, start, eax6, ok, eng_done;
  reg [31:0] ebx;
  reg [63:0] addr;
  reg [3:0] lat;
  reg [255:0] meas;
  reg [127:0] h1, h2, attr;
  reg [31:0] rows [0:13];
  wire req, mv, hv, iv, scs, busy, done, lok;
  wire [63:0] ra;
  wire [7:0] md, hb, ib;
  wire [1:0] isel;
  wire [8:0] idx;
  wire [9:0] ff;
  integer n_errors, checked, i, r, k, hc, ic, hb_ofs, ib_ofs;

  esc_checker u_dut (.clk(clk), .resetn(resetn), .start(start),
    .rec_addr(addr), .cap_ebx(ebx), .cap_eax6(eax6),
    .enclave_measurement(meas), .enclave_attributes(attr),
    .mem_rd_req(req), .mem_rd_addr(ra), .mem_rd_valid(mv),
    .mem_rd_data(md), .hash_valid(hv), .hash_byte(hb), .int_valid(iv),
    .int_sel(isel), .int_idx(idx), .int_byte(ib), .sig_check_start(scs),
    .sig_check_done(eng_done), .sig_check_ok(ok), .busy(busy),
    .done(done), .launch_ok(lok), .fail_flags(ff));
  esc_mem_model u_mem (.clk(clk), .resetn(resetn), .mem_rd_req(req),
    .mem_rd_addr(ra), .lat(lat), .mem_rd_valid(mv), .mem_rd_data(md));

  // Clock, and an engine answering the cycle after it is asked
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) eng_done <= scs;

  task chk(input [15:0] seen, input [15:0] exp, input [47:0] nm);
  begin
    checked = checked + 1;
    if (seen !== exp)
    begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED %0s exp %h seen %h", nm, exp, seen);
    end
  end
  endtask

  // Each streamed byte must be the stored byte it stands for
  always @(negedge clk)
  begin
    // Stream position gives the record offset, not the routing outputs
    hb_ofs = (hc < 128) ? hc : hc + 772;
    ib_ofs = ic + ((ic < 384) ? 128 : (ic < 768) ? 132 : 272);
    if (hv === 1'b1) chk(hb, u_mem.rec[hb_ofs], "hash");
    if (iv === 1'b1) chk(ib, u_mem.rec[ib_ofs], "int");
    if (iv === 1'b1) chk(isel * 512 + idx, (ic / 384) * 512 + ic % 384,
      "isel");
    hc = hc + (hv === 1'b1);
    ic = ic + (iv === 1'b1);
  end

  task report_and_stop;
  begin
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask

  // Start one check; poke retries start while busy, which must be ignored
  task run(input [63:0] a, input poke);
  begin
    hc = 0;
    ic = 0;
    k = 0;
    @(posedge clk);
    start <= 1'b1;
    addr <= a;
    #1;
    while (done !== 1'b1 && k < 20000)
    begin
      @(posedge clk);
      start <= poke && k == 40;
      addr <= poke ? 64'h3 : a;
      #1;
      k = k + 1;
    end
    if (k == 20000)
    begin
      n_errors = n_errors + 1;
      report_and_stop;
    end
  end
  endtask

  // Well-formed record; identifiers, select and mask left zero
  task fill;
  begin
    for (i = 0; i < 1808; i = i + 1)
      u_mem.rec[i] = (i >= 128 && i < 900 || i >= 1040) ? i ^ 90 : 0;
    for (i = 0; i < 16; i = i + 1)
    begin
      u_mem.rec[i] = h1[127 - 8 * i -: 8];
      u_mem.rec[24 + i] = h2[127 - 8 * i -: 8];
      u_mem.rec[513 + i % 3] = 8'h00;
    end
    for (i = 0; i < 32; i = i + 1)
      u_mem.rec[960 + i] = meas[8 * i +: 8];
    u_mem.rec[20] = 8'h15;
    u_mem.rec[21] = 8'h06;
    u_mem.rec[512] = 8'h03;
  end
  endtask

  // Rows: offset, byte, ebx nonzero, cap bit, engine ok, expected flags
  initial
  begin
    rows[0] = {11'd40, 8'hff, 3'b001, 10'h000};
    rows[1] = {11'd0, 8'hff, 3'b001, 10'h001};
    rows[2] = {11'd39, 8'hff, 3'b001, 10'h001};
    rows[3] = {11'd20, 8'h32, 3'b001, 10'h010};
    rows[4] = {11'd21, 8'h13, 3'b001, 10'h010};
    rows[5] = {11'd512, 8'h02, 3'b001, 10'h008};
    rows[6] = {11'd900, 8'h01, 3'b001, 10'h020};
    rows[7] = {11'd900, 8'h01, 3'b101, 10'h020};
    rows[8] = {11'd908, 8'h01, 3'b001, 10'h040};
    rows[9] = {11'd909, 8'h01, 3'b011, 10'h000};
    rows[10] = {11'd944, 8'h01, 3'b001, 10'h080};
    rows[11] = {11'd960, 8'hff, 3'b001, 10'h100};
    rows[12] = {11'd100, 8'h01, 3'b001, 10'h004};
    rows[13] = {11'd40, 8'h00, 3'b000, 10'h200};
    h1 = `ESC_HDR1_VAL;
    h2 = `ESC_HDR2_VAL;
    meas = {8{32'h9c3e5a71}} ^ 256'h1f;
    {n_errors, checked, hc, ic} = 0;
    {resetn, start, eax6, ebx, addr, lat} = 0;
    // Attribute bit 0 set, so an enforced bit 0 exposes a mismatch
    attr = 128'h1;
    ok = 1;
    repeat (10) @(posedge clk);
    chk({req, busy, done, lok, ff}, 0, "reset");
    resetn <= 1'b1;
    for (r = 0; r < 14; r = r + 1)
    begin
      fill;
      u_mem.rec[rows[r][31:21]] = rows[r][20:13];
      {ebx[0], eax6, ok} <= rows[r][12:10];
      run(64'h5000, 1'b0);
      chk(ff, rows[r][9:0], "flags");
      chk(lok, rows[r][9:0] == 0, "ok");
      chk(hc, 256, "nhash");
      chk(ic, 1536, "nint");
    end
    // Misaligned record is refused at once, nothing streamed
    run(64'h5004, 1'b0);
    chk(ff, 10'h002, "align");
    chk(hc + ic, 0, "noread");
    // Slow memory, with a stray start while busy
    fill;
    {ebx, eax6, ok, lat} <= {32'h0, 2'b01, 4'h3};
    run(64'h7000, 1'b1);
    chk({lok, ff}, 11'h400, "slow");
    chk(hc, 256, "nhash2");
    // Reset in mid-run stops the fetch; a clean run follows
    hc = 0;
    ic = 0;
    @(posedge clk);
    start <= 1'b1;
    addr <= 64'h5000;
    @(posedge clk);
    start <= 1'b0;
    repeat (100) @(posedge clk);
    resetn <= 1'b0;
    repeat (10) @(posedge clk);
    chk({req, busy, done, lok, ff}, 0, "reset2");
    resetn <= 1'b1;
    lat = 0;
    run(64'h5000, 1'b0);
    chk(lok, 1, "again");
    report_and_stop;
  end
endmodule // tb
